// ==== logic/sst_pkg.sv ====
// ****************************************************************
// Shared constants, types and decode helpers
// ****************************************************************
package sst_pkg;

  // Data path widths
  localparam int BYTE_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int DM_ADDR_W = 12;
  localparam int PM_ADDR_W = 13;
  localparam int PM_WORD_W = 16;
  localparam int TABLE_PTR_W = 8;
  localparam int PAGE_W = 5;
  localparam int BIT_SEL_W = 3;
  localparam int BUS_ADDR_W = 3;

  // Page number of the last program page
  localparam logic [PAGE_W-1:0] LAST_PAGE = 5'h1F;

  // Register offsets
  localparam logic [BUS_ADDR_W-1:0] OFS_ACCUMULATOR = 3'h0;
  localparam logic [BUS_ADDR_W-1:0] OFS_TABLE_POINTER = 3'h1;
  localparam logic [BUS_ADDR_W-1:0] OFS_TABLE_HIGH = 3'h2;
  localparam logic [BUS_ADDR_W-1:0] OFS_STATUS = 3'h3;
  localparam logic [BUS_ADDR_W-1:0] OFS_STATE = 3'h4;

  // Status field positions
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;

  // Reset values
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [PM_ADDR_W-1:0] RST_PM_ADDR = 13'h0000;
  localparam logic [DM_ADDR_W-1:0] RST_DM_ADDR = 12'h000;

  // Operation selector
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_NIBBLE_EXCHANGE_IN_PLACE = 4'h1,
    OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR = 4'h2,
    OP_SKIP_WHEN_ZERO = 4'h3,
    OP_COPY_THEN_SKIP_WHEN_ZERO = 4'h4,
    OP_BIT_SKIP_WHEN_ZERO = 4'h5,
    OP_TABLE_FETCH_CURRENT_PAGE = 4'h6,
    OP_TABLE_FETCH_LAST_PAGE = 4'h7,
    OP_EXCLUSIVE_OR_INTO_ACCUMULATOR = 4'h8,
    OP_EXCLUSIVE_OR_INTO_MEMORY = 4'h9,
    OP_EXCLUSIVE_OR_IMMEDIATE = 4'hA
  } sst_op_t;

  // Sequencer states, Gray along idle-fetch-catch and idle-dummy
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_CATCH = 2'h3,
    ST_DUMMY = 2'h2
  } sst_state_t;

  // Skip-type operation
  function automatic logic is_skip_op(input sst_op_t op);
    is_skip_op = (op == OP_SKIP_WHEN_ZERO) || (op == OP_COPY_THEN_SKIP_WHEN_ZERO) ||
                 (op == OP_BIT_SKIP_WHEN_ZERO);
  endfunction : is_skip_op

  // Table-read operation
  function automatic logic is_table_op(input sst_op_t op);
    is_table_op = (op == OP_TABLE_FETCH_CURRENT_PAGE) || (op == OP_TABLE_FETCH_LAST_PAGE);
  endfunction : is_table_op

  // Exclusive-OR operation
  function automatic logic is_xor_op(input sst_op_t op);
    is_xor_op = (op == OP_EXCLUSIVE_OR_INTO_ACCUMULATOR) ||
                (op == OP_EXCLUSIVE_OR_INTO_MEMORY) || (op == OP_EXCLUSIVE_OR_IMMEDIATE);
  endfunction : is_xor_op

endpackage : sst_pkg

// ==== logic/sst_nibble_xor_unit.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Combinational nibble exchange and exclusive-OR unit
// ****************************************************************
module sst_nibble_xor_unit
  import sst_pkg::*;
(
  input wire sst_pkg::sst_op_t op,
  input wire logic [sst_pkg::BYTE_W-1:0] working_accumulator,
  input wire logic [sst_pkg::BYTE_W-1:0] operand_byte,
  input wire logic [sst_pkg::BYTE_W-1:0] immediate_byte,
  output logic [sst_pkg::BYTE_W-1:0] result,
  output logic result_zero
);
  import sst_pkg::*;

  // Result select per operation
  always_comb begin
    case (op)
      OP_NIBBLE_EXCHANGE_IN_PLACE,
      OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR: begin
        // Low nibble goes up, high nibble goes down
        result = {operand_byte[NIBBLE_W-1:0], operand_byte[BYTE_W-1:NIBBLE_W]};
      end
      OP_EXCLUSIVE_OR_IMMEDIATE: begin
        result = working_accumulator ^ immediate_byte;
      end
      OP_EXCLUSIVE_OR_INTO_ACCUMULATOR,
      OP_EXCLUSIVE_OR_INTO_MEMORY: begin
        result = working_accumulator ^ operand_byte;
      end
      default: begin
        // Plain copy of the operand
        result = operand_byte;
      end
    endcase
  end

  // Zero detect on the full byte
  assign result_zero = (result == RST_BYTE);

endmodule : sst_nibble_xor_unit

// ==== logic/sst_exec.sv ====
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// RL1: In-place swap exchanges nibbles, writes back, no flags
// RL2: Accumulator swap loads exchanged nibbles, memory kept
// RL3: Skip next instruction when memory byte zero
// RL4: Skip uses dummy cycle; skips take two cycles
// RL5: Copy byte to accumulator, skip if zero
// RL6: Skip next when selected bit is zero
// RL7: Current-page table read: low to memory, high latched
// RL8: Last-page table read: low to memory, high latched
// RL9: XOR memory into accumulator, zero flag only
// RL10: XOR accumulator into memory, zero flag only
// RL11: XOR immediate into accumulator, zero flag only
// RL12: Zero flag from result; other flags kept
module sst_exec
  import sst_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic exec_start,
  input wire sst_pkg::sst_op_t exec_op,
  input wire logic [sst_pkg::BYTE_W-1:0] operand_byte,
  input wire logic [sst_pkg::BYTE_W-1:0] immediate_byte,
  input wire logic [sst_pkg::BIT_SEL_W-1:0] bit_select,
  input wire logic [sst_pkg::DM_ADDR_W-1:0] operand_addr,
  input wire logic [sst_pkg::PAGE_W-1:0] current_page,
  input wire logic [sst_pkg::PM_WORD_W-1:0] pm_rdata,
  output logic pm_rd,
  output logic [sst_pkg::PM_ADDR_W-1:0] pm_addr,
  output logic dm_we,
  output logic [sst_pkg::DM_ADDR_W-1:0] dm_addr,
  output logic [sst_pkg::BYTE_W-1:0] dm_wdata,
  output logic skip_next,
  output logic exec_done,
  output logic exec_busy,
  output logic [sst_pkg::BYTE_W-1:0] working_accumulator,
  output logic [sst_pkg::BYTE_W-1:0] table_high_byte_latch,
  output logic zero_flag,
  input wire logic [sst_pkg::BUS_ADDR_W-1:0] bus_addr,
  input wire logic [sst_pkg::BYTE_W-1:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [sst_pkg::BYTE_W-1:0] bus_rdata
);
  import sst_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn); // Checks sleep during reset

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sst_state_t state_reg; // Sequencer state
  sst_state_t state_next; // Its next value
  logic [BYTE_W-1:0] accum_reg; // Working accumulator
  logic [BYTE_W-1:0] status_reg; // Flags C, AC, Z, OV
  logic [TABLE_PTR_W-1:0] table_word_pointer_reg; // Table pointer
  logic [BYTE_W-1:0] table_high_reg; // High byte of fetched word
  logic [DM_ADDR_W-1:0] hold_addr_reg; // Destination of a table read
  logic pm_rd_reg; // Program read strobe
  logic [PM_ADDR_W-1:0] pm_addr_reg; // Program read address
  logic dm_we_reg; // Data write strobe
  logic [DM_ADDR_W-1:0] dm_addr_reg; // Data write address
  logic [BYTE_W-1:0] dm_wdata_reg; // Data write value
  logic skip_reg; // Next instruction suppressed
  logic done_reg; // Instruction retired
  logic [BYTE_W-1:0] rdata_reg; // Read data, one cycle late
  logic exec_fire; // Request accepted this cycle
  logic skip_taken; // Skip condition of the request
  logic sel_bit; // Selected operand bit
  logic [BYTE_W-1:0] unit_result; // Swap or XOR result
  logic unit_zero; // Result is zero

  // Request only taken while idle
  assign exec_fire = exec_start && (state_reg == ST_IDLE);
  assign exec_busy = (state_reg != ST_IDLE);
  assign sel_bit = operand_byte[bit_select];
  // Skip condition per skip operation
  always_comb begin
    case (exec_op)
      OP_SKIP_WHEN_ZERO: skip_taken = (operand_byte == RST_BYTE); // RL3
      OP_COPY_THEN_SKIP_WHEN_ZERO: skip_taken = (operand_byte == RST_BYTE); // RL5
      OP_BIT_SKIP_WHEN_ZERO: skip_taken = !sel_bit; // RL6
      default: skip_taken = 1'b0;
    endcase
  end

  // ****************************************************************
  // Data path unit
  // ****************************************************************
  sst_nibble_xor_unit u_unit (.op(exec_op), .working_accumulator(accum_reg),
    .operand_byte(operand_byte), .immediate_byte(immediate_byte),
    .result(unit_result), .result_zero(unit_zero));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (exec_fire && is_skip_op(exec_op)) begin
          state_next = ST_DUMMY; // RL4
        end else if (exec_fire && is_table_op(exec_op)) begin
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: state_next = ST_CATCH;
      ST_CATCH: state_next = ST_IDLE;
      ST_DUMMY: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Architectural registers
  // ****************************************************************
  // Accumulator: execution wins over a bus write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      accum_reg <= RST_BYTE;
    end else if (exec_fire && (exec_op == OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR)) begin
      accum_reg <= unit_result; // RL2
    end else if (exec_fire && (exec_op == OP_COPY_THEN_SKIP_WHEN_ZERO)) begin
      accum_reg <= operand_byte; // RL5
    end else if (exec_fire && ((exec_op == OP_EXCLUSIVE_OR_INTO_ACCUMULATOR) ||
                               (exec_op == OP_EXCLUSIVE_OR_IMMEDIATE))) begin
      accum_reg <= unit_result; // RL9 RL11
    end else if (bus_we && (bus_addr == OFS_ACCUMULATOR)) begin
      accum_reg <= bus_wdata;
    end
  end

  // Flags: only the XOR group touches zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= RST_BYTE;
    end else begin
      if (bus_we && (bus_addr == OFS_STATUS)) begin
        status_reg <= bus_wdata;
      end
      if (exec_fire && is_xor_op(exec_op)) begin
        status_reg[FLAG_Z] <= unit_zero; // RL12
      end
    end
  end
  // Table pointer, set by software only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      table_word_pointer_reg <= RST_BYTE;
    end else if (bus_we && (bus_addr == OFS_TABLE_POINTER)) begin
      table_word_pointer_reg <= bus_wdata;
    end
  end
  // High byte latch, loaded when the word arrives
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      table_high_reg <= RST_BYTE;
    end else if (state_reg == ST_CATCH) begin
      table_high_reg <= pm_rdata[PM_WORD_W-1:BYTE_W]; // RL7 RL8
    end
  end

  // ****************************************************************
  // Program memory port
  // ****************************************************************
  // Address from page and table pointer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pm_rd_reg <= 1'b0;
      pm_addr_reg <= RST_PM_ADDR;
      hold_addr_reg <= RST_DM_ADDR;
    end else begin
      pm_rd_reg <= exec_fire && is_table_op(exec_op);
      if (exec_fire && (exec_op == OP_TABLE_FETCH_CURRENT_PAGE)) begin
        pm_addr_reg <= {current_page, table_word_pointer_reg}; // RL7
        hold_addr_reg <= operand_addr;
      end else if (exec_fire && (exec_op == OP_TABLE_FETCH_LAST_PAGE)) begin
        pm_addr_reg <= {LAST_PAGE, table_word_pointer_reg}; // RL8
        hold_addr_reg <= operand_addr;
      end
    end
  end

  // ****************************************************************
  // Data memory write port
  // ****************************************************************
  // One write strobe per storing instruction
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dm_we_reg <= 1'b0;
      dm_addr_reg <= RST_DM_ADDR;
      dm_wdata_reg <= RST_BYTE;
    end else if (state_reg == ST_CATCH) begin
      dm_we_reg <= 1'b1;
      dm_addr_reg <= hold_addr_reg;
      dm_wdata_reg <= pm_rdata[BYTE_W-1:0]; // RL7 RL8
    end else if (exec_fire && ((exec_op == OP_NIBBLE_EXCHANGE_IN_PLACE) ||
                               (exec_op == OP_EXCLUSIVE_OR_INTO_MEMORY))) begin
      dm_we_reg <= 1'b1;
      dm_addr_reg <= operand_addr;
      dm_wdata_reg <= unit_result; // RL1 RL10
    end else begin
      dm_we_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Skip and retire
  // ****************************************************************
  // Skip marks the dummy cycle, done marks retirement
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      skip_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      skip_reg <= exec_fire && skip_taken; // RL3 RL4
      done_reg <= (exec_fire && !is_skip_op(exec_op) && !is_table_op(exec_op)) ||
                  (state_reg == ST_DUMMY) || (state_reg == ST_CATCH); // RL4
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= RST_BYTE;
    end else if (bus_re) begin
      case (bus_addr)
        OFS_ACCUMULATOR: rdata_reg <= accum_reg;
        OFS_TABLE_POINTER: rdata_reg <= table_word_pointer_reg;
        OFS_TABLE_HIGH: rdata_reg <= table_high_reg;
        OFS_STATUS: rdata_reg <= status_reg;
        OFS_STATE: rdata_reg <= {{(BYTE_W-2){1'b0}}, state_reg};
        default: rdata_reg <= RST_BYTE;
      endcase
    end else begin
      rdata_reg <= RST_BYTE;
    end
  end
  // Outputs from flip-flops
  assign pm_rd = pm_rd_reg;
  assign pm_addr = pm_addr_reg;
  assign dm_we = dm_we_reg;
  assign dm_addr = dm_addr_reg;
  assign dm_wdata = dm_wdata_reg;
  assign skip_next = skip_reg;
  assign exec_done = done_reg;
  assign working_accumulator = accum_reg;
  assign table_high_byte_latch = table_high_reg;
  assign zero_flag = status_reg[FLAG_Z];
  assign bus_rdata = rdata_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_swap_mem;
    exec_fire && (exec_op == OP_NIBBLE_EXCHANGE_IN_PLACE) && !bus_we |=>
      dm_we && (dm_wdata == {$past(operand_byte[3:0]), $past(operand_byte[7:4])}) &&
      (status_reg == $past(status_reg));
  endproperty
  a_swap_mem: assert property (p_swap_mem) else $error("in-place swap wrong"); // RL1
  property p_swap_accum;
    exec_fire && (exec_op == OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR) |=> !dm_we &&
      (accum_reg == {$past(operand_byte[3:0]), $past(operand_byte[7:4])});
  endproperty
  a_swap_accum: assert property (p_swap_accum) else $error("accumulator swap wrong"); // RL2
  property p_skip_zero;
    exec_fire && (exec_op == OP_SKIP_WHEN_ZERO) |=>
      (skip_next == ($past(operand_byte) == RST_BYTE)) && !dm_we;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("byte skip wrong"); // RL3
  property p_skip_two_cycles;
    exec_fire && is_skip_op(exec_op) |=> exec_busy && !exec_done ##1 exec_done && !exec_busy;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip not two cycles"); // RL4
  property p_copy_skip;
    exec_fire && (exec_op == OP_COPY_THEN_SKIP_WHEN_ZERO) |=>
      (accum_reg == $past(operand_byte)) && (skip_next == (accum_reg == RST_BYTE));
  endproperty
  a_copy_skip: assert property (p_copy_skip) else $error("copy skip wrong"); // RL5
  property p_bit_skip;
    exec_fire && (exec_op == OP_BIT_SKIP_WHEN_ZERO) |=> skip_next == !$past(sel_bit);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong"); // RL6
  property p_table_current;
    exec_fire && (exec_op == OP_TABLE_FETCH_CURRENT_PAGE) |=>
      pm_rd && (pm_addr[12:8] == $past(current_page)) ##2 dm_we && exec_done;
  endproperty
  a_table_current: assert property (p_table_current) else $error("table read wrong"); // RL7
  property p_table_last;
    exec_fire && (exec_op == OP_TABLE_FETCH_LAST_PAGE) |=>
      pm_rd && (pm_addr[12:8] == LAST_PAGE) ##2 dm_we && exec_done;
  endproperty
  a_table_last: assert property (p_table_last) else $error("last page read wrong"); // RL8
  property p_table_data;
    (state_reg == ST_CATCH) |=> (dm_wdata == $past(pm_rdata[7:0])) &&
      (table_high_byte_latch == $past(pm_rdata[15:8]));
  endproperty
  a_table_data: assert property (p_table_data) else $error("table bytes wrong"); // RL7
  property p_xor_accum;
    exec_fire && (exec_op == OP_EXCLUSIVE_OR_INTO_ACCUMULATOR) |=>
      accum_reg == ($past(accum_reg) ^ $past(operand_byte));
  endproperty
  a_xor_accum: assert property (p_xor_accum) else $error("xor to accumulator wrong"); // RL9
  property p_xor_mem;
    exec_fire && (exec_op == OP_EXCLUSIVE_OR_INTO_MEMORY) |=>
      dm_we && (dm_wdata == ($past(accum_reg) ^ $past(operand_byte))) &&
      (accum_reg == $past(accum_reg) || $past(bus_we));
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong"); // RL10
  property p_xor_imm;
    exec_fire && (exec_op == OP_EXCLUSIVE_OR_IMMEDIATE) |=>
      accum_reg == ($past(accum_reg) ^ $past(immediate_byte));
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong"); // RL11
  property p_xor_flags;
    exec_fire && is_xor_op(exec_op) && !bus_we |=> (zero_flag == $past(unit_zero)) &&
      (status_reg[FLAG_AC:FLAG_C] == $past(status_reg[FLAG_AC:FLAG_C])) &&
      (status_reg[FLAG_OV] == $past(status_reg[FLAG_OV]));
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong"); // RL12
  // Main scenarios
  c_skip_taken: cover property (skip_next);
  c_table_read: cover property ((state_reg == ST_CATCH) ##1 dm_we);
  c_xor_zero: cover property (exec_fire && is_xor_op(exec_op) && unit_zero);

endmodule : sst_exec

// ==== sim/sst_pm_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Program memory stand-in for table reads
// ****************************************************************
module sst_pm_model
  import sst_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic pm_rd,
  input wire logic [sst_pkg::PM_ADDR_W-1:0] pm_addr,
  output logic [sst_pkg::PM_WORD_W-1:0] pm_rdata
);
  import sst_pkg::*;
  // Word valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pm_rdata <= 16'hFFFF;
    end else if (pm_rd) begin
      // High byte carries the page, low byte the scrambled pointer
      pm_rdata <= {3'h0, pm_addr[12:8], pm_addr[7:0] ^ 8'hA5};
    end else begin
      // Stale word flips each cycle so late capture shows
      pm_rdata <= ~pm_rdata;
    end
  end
endmodule : sst_pm_model

// ==== sim/sst_exec_tb_top.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Bench for the execution block
// ****************************************************************
module sst_exec_tb_top;
  import sst_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic exec_start = 1'b0;
  sst_op_t exec_op = OP_NONE;
  logic [7:0] operand_byte = 8'h00;
  logic [7:0] immediate_byte = 8'h00;
  logic [2:0] bit_select = 3'h0;
  logic [11:0] operand_addr = 12'h000;
  logic [4:0] current_page = 5'h00;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_we = 1'b0;
  logic bus_re = 1'b0;
  logic [15:0] pm_rdata;
  logic pm_rd, dm_we, skip_next, exec_done, exec_busy, zero_flag;
  logic [12:0] pm_addr;
  logic [11:0] dm_addr;
  logic [7:0] dm_wdata, working_accumulator, table_high_byte_latch, bus_rdata, rd;
  logic [15:0] got_cyc;
  logic got_skip, got_we, got_pmrd;
  int n_errors = 0;
  int n_tests = 0;

  // Free-running core clock
  always #10 clk = ~clk;

  sst_exec u_sst_exec (.clk(clk), .resetn(resetn), .exec_start(exec_start),
    .exec_op(exec_op), .operand_byte(operand_byte), .immediate_byte(immediate_byte),
    .bit_select(bit_select), .operand_addr(operand_addr), .current_page(current_page),
    .pm_rdata(pm_rdata), .pm_rd(pm_rd), .pm_addr(pm_addr), .dm_we(dm_we),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .skip_next(skip_next), .exec_done(exec_done),
    .exec_busy(exec_busy), .working_accumulator(working_accumulator),
    .table_high_byte_latch(table_high_byte_latch), .zero_flag(zero_flag),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
    .bus_rdata(bus_rdata));

  sst_pm_model u_sst_pm_model (.clk(clk), .resetn(resetn), .pm_rd(pm_rd),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Verdict and end of run
  task automatic wrap_up();
    $display("Counts: tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // Four-state value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle register write
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_we <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_we <= 1'b0;
  endtask : bus_wr

  // One-cycle register read, data taken the cycle after
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_re <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_re <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : bus_rd

  // Issue one operation, gather pulses until retirement
  task automatic run(input sst_op_t op, input logic [7:0] m, input logic [7:0] x,
                     input logic [2:0] b, input logic [11:0] a);
    @(posedge clk);
    exec_start <= 1'b1;
    exec_op <= op;
    operand_byte <= m;
    immediate_byte <= x;
    bit_select <= b;
    operand_addr <= a;
    got_cyc = 16'h0000;
    got_skip = 1'b0;
    got_we = 1'b0;
    got_pmrd = 1'b0;
    repeat (8) begin
      @(posedge clk);
      exec_start <= 1'b0;
      #1;
      got_cyc = got_cyc + 16'h0001;
      got_skip = got_skip | (skip_next === 1'b1);
      got_we = got_we | (dm_we === 1'b1);
      got_pmrd = got_pmrd | (pm_rd === 1'b1);
      if (exec_done === 1'b1) break;
    end
    // Bounded wait ran out
    if (exec_done !== 1'b1) begin
      chk(16'(exec_done), 16'h0001);
      wrap_up();
    end
  endtask : run

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, then release
  task automatic t_reset();
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({working_accumulator, table_high_byte_latch}, 16'h0000);
    chk({zero_flag, exec_busy, dm_we, exec_done}, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  // Exclusive-OR variants and status flags
  task automatic t_xor();
    bus_wr(OFS_ACCUMULATOR, 8'h5A);
    bus_wr(OFS_STATUS, 8'h0B);
    run(OP_EXCLUSIVE_OR_INTO_ACCUMULATOR, 8'h5A, 8'h00, 3'h0, 12'h020);
    chk({working_accumulator, 7'h00, zero_flag}, 16'h0001);
    chk({got_cyc[7:0], 7'h00, got_we}, 16'h0100);
    bus_rd(OFS_STATUS, rd);
    chk(16'(rd), 16'h000F);
    run(OP_EXCLUSIVE_OR_INTO_MEMORY, 8'h33, 8'h00, 3'h0, 12'hABC);
    chk({dm_wdata, 7'h00, got_we}, 16'h3301);
    chk({4'h0, dm_addr}, 16'h0ABC);
    chk({working_accumulator, 7'h00, zero_flag}, 16'h0000);
    run(OP_EXCLUSIVE_OR_IMMEDIATE, 8'hFF, 8'hF0, 3'h0, 12'h021);
    chk({working_accumulator, 7'h00, zero_flag}, 16'hF000);
    bus_rd(OFS_STATUS, rd);
    chk(16'(rd), 16'h000B);
    $display("test xor done");
  endtask : t_xor

  // Nibble exchanges leave the zero flag alone
  task automatic t_swap();
    bus_wr(OFS_STATUS, 8'h04);
    run(OP_NIBBLE_EXCHANGE_IN_PLACE, 8'h3C, 8'h00, 3'h0, 12'h123);
    chk({dm_wdata, 7'h00, got_we}, 16'hC301);
    chk({4'h0, dm_addr}, 16'h0123);
    run(OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR, 8'hA5, 8'h00, 3'h0, 12'h124);
    chk({working_accumulator, 7'h00, got_we}, 16'h5A00);
    chk(16'(dm_wdata), 16'h00C3);
    // Idle code retires at once and stores nothing
    run(OP_NONE, 8'h77, 8'h00, 3'h0, 12'h125);
    chk({got_cyc[7:0], 7'h00, got_we}, 16'h0100);
    bus_rd(OFS_STATUS, rd);
    chk(16'(rd), 16'h0004);
    $display("test swap done");
  endtask : t_swap

  // Every skip kind, taken and not taken
  task automatic t_skip();
    sst_op_t ops [6] = '{OP_SKIP_WHEN_ZERO, OP_SKIP_WHEN_ZERO, OP_COPY_THEN_SKIP_WHEN_ZERO,
                         OP_COPY_THEN_SKIP_WHEN_ZERO, OP_BIT_SKIP_WHEN_ZERO,
                         OP_BIT_SKIP_WHEN_ZERO};
    logic [7:0] vals [6] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'hF7, 8'h08};
    bus_wr(OFS_STATUS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      run(ops[i], vals[i], 8'h00, 3'h3, 12'h010);
      chk(got_cyc, 16'h0002);
      chk({7'h00, got_skip, 7'h00, got_we}, {7'h00, (i % 2 == 0), 8'h00});
      // Copy variant loads the accumulator
      if (i == 2 || i == 3) chk(16'(working_accumulator), 16'(vals[i]));
    end
    bus_rd(OFS_STATUS, rd);
    chk(16'(rd), 16'h0000);
    $display("test skip done");
  endtask : t_skip

  // Table reads from current and last page
  task automatic t_table();
    bus_wr(OFS_TABLE_POINTER, 8'h47);
    current_page <= 5'h0A;
    run(OP_TABLE_FETCH_CURRENT_PAGE, 8'h00, 8'h00, 3'h0, 12'h345);
    chk(got_cyc, 16'h0003);
    chk({3'h0, pm_addr}, 16'h0A47);
    chk({dm_wdata, table_high_byte_latch}, 16'hE20A);
    chk({4'h0, dm_addr}, 16'h0345);
    chk({7'h00, got_pmrd, 7'h00, got_we}, 16'h0101);
    bus_wr(OFS_TABLE_POINTER, 8'hB9);
    run(OP_TABLE_FETCH_LAST_PAGE, 8'h00, 8'h00, 3'h0, 12'h346);
    chk({3'h0, pm_addr}, 16'h1FB9);
    chk({dm_wdata, table_high_byte_latch}, 16'h1C1F);
    bus_wr(OFS_TABLE_HIGH, 8'h55);
    bus_rd(OFS_TABLE_HIGH, rd);
    chk(16'(rd), 16'h001F);
    bus_rd(3'h5, rd);
    chk(16'(rd), 16'h0000);
    $display("test table done");
  endtask : t_table

  // Main sequence
  initial begin
    t_reset();
    t_xor();
    t_swap();
    t_skip();
    t_table();
    wrap_up();
  end
endmodule : sst_exec_tb_top
